// ==== rtl/msc_pkg.sv ====
// package: constants for the supply system control block
package msc_pkg;
  // channel count and register bus widths
  localparam int unsigned NCH      = 8;
  localparam int unsigned AW       = 8;
  localparam int unsigned DW       = 32;
  // register offsets (byte addresses)
  localparam logic [7:0]  CTRL_OFS = 8'h00;
  localparam logic [7:0]  CHAN_OFS = 8'h04;
  localparam logic [7:0]  STAT_OFS = 8'h08;
  // control register fields
  localparam int unsigned CTRL_SW_KILL     = 0;
  localparam int unsigned CTRL_RESTORE     = 1;
  localparam int unsigned CTRL_SYNC_MASTER = 2;
  localparam int unsigned CTRL_CPU_RST_EN  = 3;
  localparam int unsigned CTRL_BRD_RST_EN  = 4;
  localparam int unsigned CTRL_FLAG_CPU    = 5;
  localparam int unsigned CTRL_FLAG_BRD    = 6;
  localparam int unsigned CTRL_W           = 7;
  localparam logic [6:0]  CTRL_RST_VAL     = 7'h00;
  localparam logic [7:0]  CHAN_RST_VAL     = 8'h00;
  // status register fields
  localparam int unsigned STAT_ENABLED   = 0;
  localparam int unsigned STAT_KILL      = 1;
  localparam int unsigned STAT_INTERLOCK = 2;
  localparam int unsigned STAT_RST_FLAG  = 3;
  localparam int unsigned STAT_VOLTAGE_SELECT_IN      = 4;
  localparam int unsigned STAT_CURRENT_SELECT_IN      = 5;
  localparam int unsigned STAT_MASTER    = 6;
  localparam int unsigned STAT_NIM       = 7;
  localparam int unsigned STAT_POWER     = 8;
  localparam int unsigned STAT_W         = 9;
  // timing
  localparam int unsigned CLK_FREQ_KHZ        = 125000;
  localparam int unsigned CPU_RESET_HOLD_MS   = 100;
  localparam int unsigned BOARD_RESET_XTRA_MS = 900;
  localparam int unsigned REMOTE_OUT_DELAY_MS = 3000;
  localparam int unsigned SYNC_FREQ_KHZ       = 1250;
  localparam int unsigned CPU_HOLD_CYC        = CPU_RESET_HOLD_MS * CLK_FREQ_KHZ;
  localparam int unsigned BOARD_HOLD_CYC      = (CPU_RESET_HOLD_MS + BOARD_RESET_XTRA_MS) * CLK_FREQ_KHZ;
  localparam int unsigned REMOTE_DELAY_CYC    = REMOTE_OUT_DELAY_MS * CLK_FREQ_KHZ;
  localparam int unsigned SYNC_HALF_CYC       = CLK_FREQ_KHZ / (2 * SYNC_FREQ_KHZ);
  // synchronised pin bits
  localparam int unsigned PIN_W = 15;
  // reset classifier states
  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_HELD = 2'b10
  } msc_rst_e;
endpackage : msc_pkg

// ==== rtl/msc_sync.sv ====
// two flip-flop synchroniser bank for external pins
`timescale 1ns/10ps
module msc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // first stage only feeds the second stage
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule : msc_sync

// ==== rtl/msc_top.sv ====
// system control logic of the supply crate: switches, commands, resets, sync clock
`timescale 1ns/10ps
module msc_top
  import msc_pkg::*;
#(
  parameter int unsigned CPU_HOLD      = msc_pkg::CPU_HOLD_CYC,
  parameter int unsigned BOARD_HOLD    = msc_pkg::BOARD_HOLD_CYC,
  parameter int unsigned REMOTE_DELAY  = msc_pkg::REMOTE_DELAY_CYC
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // register port
  input  wire logic [msc_pkg::AW-1:0]    reg_addr,
  input  wire logic [msc_pkg::DW-1:0]    reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [msc_pkg::DW-1:0]    reg_rdata,
  // front panel switches and input lines
  input  wire logic                      std_left_in,
  input  wire logic                      key_local_in,
  input  wire logic                      key_remote_in,
  input  wire logic                      remote_power_in,
  input  wire logic                      mains_on_in,
  input  wire logic                      local_enable_position,
  input  wire logic                      remote_enable_position,
  input  wire logic                      enable_in,
  input  wire logic                      voltage_select_in,
  input  wire logic                      current_select_in,
  input  wire logic                      kill_in,
  input  wire logic                      reset_in,
  input  wire logic                      interlock_closed_in,
  input  wire logic                      interlock_pol_open_in,
  input  wire logic                      supply_sync_clock_in,
  // power and daisy chain
  output logic                           power_on_out,
  output logic                           remote_power_out,
  // channel control
  output logic      [msc_pkg::NCH-1:0]   ch_output_on,
  output logic                           ch_ramp_fast,
  output logic                           voltage_setpoint_b_sel,
  output logic                           current_limit_b_sel,
  output logic                           cpu_reset_out,
  output logic                           board_reset_out,
  // status outputs and indicators
  output logic                           status_std_nim,
  output logic                           nim_led,
  output logic                           ttl_led,
  output logic                           local_enable_led,
  output logic                           remote_enable_led,
  output logic                           voltage_select_in_led,
  output logic                           current_select_in_led,
  output logic                           kill_led,
  output logic                           reset_red_led,
  output logic                           reset_orange_led,
  output logic                           interlock_led,
  output logic                           master_led,
  output logic                           reset_flag_out,
  output logic                           any_channel_on_out,
  // sync connector, two-way
  output logic                           supply_sync_clock_out,
  output logic                           supply_sync_clock_oe,
  output logic                           supply_sync_clock
);
  import msc_pkg::*;

  logic [PIN_W-1:0]  pin_raw;
  logic [PIN_W-1:0]  pin_s;
  logic              std_left_s, key_local_s, key_remote_s, remote_pw_s, mains_s;
  logic              loc_pos_s, rem_pos_s, enable_s, voltage_select_in_s, current_select_in_s, kill_s;
  logic              reset_s, ilk_closed_s, ilk_pol_open_s, sync_in_s;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [NCH-1:0]    chan_reg;
  logic              flag_reg;
  logic [31:0]       hold_cnt_reg;
  logic [31:0]       remote_cnt_reg;
  logic [31:0]       sync_cnt_reg;
  logic              sync_gen_reg;
  msc_rst_e          rst_state_reg;
  logic              cpu_rst_pulse_reg;
  logic              brd_rst_pulse_reg;
  logic              remote_out_reg;
  logic [DW-1:0]     rdata_reg;
  logic              kill_act;
  logic              ilk_act;
  logic              enabled;
  logic              cpu_rst_ev;
  logic              brd_rst_ev;
  logic              flag_clr;
  logic              refuse_on;
  logic [STAT_W-1:0] stat_word;

  // every pin crosses two flip-flops; level translation is in the front end, so either standard reads alike
  assign pin_raw = {supply_sync_clock_in, interlock_pol_open_in, interlock_closed_in, reset_in, kill_in,
                    current_select_in, voltage_select_in, enable_in, remote_enable_position,
                    local_enable_position, mains_on_in, remote_power_in, key_remote_in, key_local_in,
                    std_left_in};

  msc_sync #(
    .W        (PIN_W)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  assign {sync_in_s, ilk_pol_open_s, ilk_closed_s, reset_s, kill_s, current_select_in_s, voltage_select_in_s, enable_s,
          rem_pos_s, loc_pos_s, mains_s, remote_pw_s, key_remote_s, key_local_s, std_left_s} = pin_s;

  // output standard select and its indicators
  assign status_std_nim = std_left_s;
  assign nim_led        = std_left_s;
  assign ttl_led        = !std_left_s;

  // power key: centre keeps off; rear mains switch must be on for either path
  assign power_on_out = mains_s & (key_local_s | (key_remote_s & remote_pw_s));

  // daisy chain output waits a few seconds of steady remote input
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remote_cnt_reg <= 32'h0;
      remote_out_reg <= 1'b0;
    end
    else if (!remote_pw_s)
    begin
      remote_cnt_reg <= 32'h0;
      remote_out_reg <= 1'b0;
    end
    else if (remote_cnt_reg >= REMOTE_DELAY - 1)
    begin
      remote_out_reg <= 1'b1;
    end
    else
    begin
      remote_cnt_reg <= remote_cnt_reg + 32'h1;
    end
  end
  assign remote_power_out = remote_out_reg;

  // enable mode: centre disables, upper local, lower follows enable line
  assign enabled           = loc_pos_s | (rem_pos_s & enable_s);
  assign local_enable_led  = loc_pos_s;
  assign remote_enable_led = rem_pos_s & enable_s;

  // setpoint and limit select go to every channel; channel ramps at its own rate
  assign voltage_setpoint_b_sel = voltage_select_in_s;
  assign voltage_select_in_led               = voltage_select_in_s;
  assign current_limit_b_sel    = current_select_in_s;
  assign current_select_in_led               = current_select_in_s;

  // kill from pin or software
  assign kill_act = kill_s | ctrl_reg[CTRL_SW_KILL];
  assign kill_led = kill_act;

  // interlock polarity: upper triggers on open contact, lower on grounded contact
  assign ilk_act       = ilk_pol_open_s ? !ilk_closed_s : ilk_closed_s;
  assign interlock_led = ilk_act;
  assign refuse_on     = ilk_act | kill_act;

  // channel drive: enable gates the stored state, so disable then enable brings back the old state
  assign ch_output_on = enabled ? chan_reg : {NCH{1'b0}};
  // fast rate only for kill, interlock and board reset; disable and select changes use channel ramps
  assign ch_ramp_fast = kill_act | ilk_act | brd_rst_pulse_reg;
  assign any_channel_on_out = |ch_output_on;

  // reset hold measurement; classification waits for the release
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_state_reg <= RS_IDLE;
      hold_cnt_reg  <= 32'h0;
    end
    else
    begin
      unique case (rst_state_reg)
        RS_IDLE:
        begin
          hold_cnt_reg <= 32'h0;
          if (reset_s)
          begin
            rst_state_reg <= RS_HELD;
            hold_cnt_reg  <= 32'h1;
          end
        end
        RS_HELD:
        begin
          if (!reset_s)
          begin
            rst_state_reg <= RS_IDLE;
          end
          else if (hold_cnt_reg != 32'hffffffff)
          begin
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
          end
        end
      endcase
    end
  end

  // release events, each gated by its software enable; a type not enabled is dropped
  assign cpu_rst_ev = (rst_state_reg == RS_HELD) && !reset_s && hold_cnt_reg > CPU_HOLD
                      && hold_cnt_reg <= BOARD_HOLD && ctrl_reg[CTRL_CPU_RST_EN];
  assign brd_rst_ev = (rst_state_reg == RS_HELD) && !reset_s && hold_cnt_reg > BOARD_HOLD
                      && ctrl_reg[CTRL_BRD_RST_EN];

  // reset colour while held: red past the first threshold, orange past the second
  assign reset_red_led    = (rst_state_reg == RS_HELD) && hold_cnt_reg > CPU_HOLD
                            && hold_cnt_reg <= BOARD_HOLD;
  assign reset_orange_led = (rst_state_reg == RS_HELD) && hold_cnt_reg > BOARD_HOLD;

  // one-cycle reset pulses toward controller and boards
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_rst_pulse_reg <= 1'b0;
      brd_rst_pulse_reg <= 1'b0;
    end
    else
    begin
      cpu_rst_pulse_reg <= cpu_rst_ev | brd_rst_ev;
      brd_rst_pulse_reg <= brd_rst_ev;
    end
  end
  assign cpu_reset_out   = cpu_rst_pulse_reg;
  assign board_reset_out = brd_rst_pulse_reg;

  // reset flag: sticky, set by the selected reset types, write one to clear; set wins
  assign flag_clr = reg_wr && reg_addr == STAT_OFS && reg_wdata[STAT_RST_FLAG];
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_reg <= 1'b0;
    end
    else if ((cpu_rst_ev && ctrl_reg[CTRL_FLAG_CPU]) || (brd_rst_ev && ctrl_reg[CTRL_FLAG_BRD]))
    begin
      flag_reg <= 1'b1;
    end
    else if (flag_clr)
    begin
      flag_reg <= 1'b0;
    end
  end
  assign reset_flag_out = flag_reg;

  // control register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= CTRL_RST_VAL;
    end
    else if (reg_wr && reg_addr == CTRL_OFS)
    begin
      ctrl_reg <= reg_wdata[CTRL_W-1:0];
    end
  end

  // channel on/off state: kill and interlock force off, on requests refused meanwhile
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_reg <= CHAN_RST_VAL;
    end
    else if (refuse_on)
    begin
      chan_reg <= {NCH{1'b0}};
    end
    else if (brd_rst_pulse_reg && !ctrl_reg[CTRL_RESTORE])
    begin
      chan_reg <= {NCH{1'b0}};
    end
    else if (reg_wr && reg_addr == CHAN_OFS)
    begin
      chan_reg <= reg_wdata[NCH-1:0];
    end
  end
  // controller reset leaves chan_reg alone, and with restore set a board reset keeps it too

  // sync clock: divider in master mode, connector input in slave mode
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_cnt_reg <= 32'h0;
      sync_gen_reg <= 1'b0;
    end
    else if (!ctrl_reg[CTRL_SYNC_MASTER])
    begin
      sync_cnt_reg <= 32'h0;
      sync_gen_reg <= 1'b0;
    end
    else if (sync_cnt_reg >= SYNC_HALF_CYC - 1)
    begin
      sync_cnt_reg <= 32'h0;
      sync_gen_reg <= !sync_gen_reg;
    end
    else
    begin
      sync_cnt_reg <= sync_cnt_reg + 32'h1;
    end
  end
  assign supply_sync_clock_out = sync_gen_reg;
  assign supply_sync_clock_oe  = ctrl_reg[CTRL_SYNC_MASTER];
  assign master_led            = ctrl_reg[CTRL_SYNC_MASTER];
  // slave clock is resynchronised, so it only suits slow consumers; at 1.25 MHz there is margin
  assign supply_sync_clock     = ctrl_reg[CTRL_SYNC_MASTER] ? sync_gen_reg : sync_in_s;

  // status word
  always_comb
  begin
    stat_word                 = '0;
    stat_word[STAT_ENABLED]   = enabled;
    stat_word[STAT_KILL]      = kill_act;
    stat_word[STAT_INTERLOCK] = ilk_act;
    stat_word[STAT_RST_FLAG]  = flag_reg;
    stat_word[STAT_VOLTAGE_SELECT_IN]      = voltage_select_in_s;
    stat_word[STAT_CURRENT_SELECT_IN]      = current_select_in_s;
    stat_word[STAT_MASTER]    = ctrl_reg[CTRL_SYNC_MASTER];
    stat_word[STAT_NIM]       = std_left_s;
    stat_word[STAT_POWER]     = power_on_out;
  end

  // read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= '0;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        CTRL_OFS: rdata_reg <= {{(DW-CTRL_W){1'b0}}, ctrl_reg};
        CHAN_OFS: rdata_reg <= {{(DW-NCH){1'b0}}, chan_reg};
        STAT_OFS: rdata_reg <= {{(DW-STAT_W){1'b0}}, stat_word};
        default:  rdata_reg <= '0;
      endcase
    end
    else
    begin
      rdata_reg <= '0;
    end
  end
  assign reg_rdata = rdata_reg;
endmodule : msc_top

// ==== tb/msc_top_asserts.sv ====
// checker: pin-level assertions for the supply system control block
`timescale 1ns/10ps
module msc_top_asserts
  import msc_pkg::*;
#(
  parameter int unsigned REMOTE_DELAY = 30
) (
  input wire logic           clk_sys,
  input wire logic           rst_n,
  input wire logic           mains_on_in,
  input wire logic           key_local_in,
  input wire logic           key_remote_in,
  input wire logic           remote_power_in,
  input wire logic           local_enable_position,
  input wire logic           remote_enable_position,
  input wire logic           enable_in,
  input wire logic           power_on_out,
  input wire logic           remote_power_out,
  input wire logic [NCH-1:0] ch_output_on,
  input wire logic           ch_ramp_fast,
  input wire logic           cpu_reset_out,
  input wire logic           board_reset_out,
  input wire logic           local_enable_led,
  input wire logic           remote_enable_led,
  input wire logic           kill_led,
  input wire logic           interlock_led,
  input wire logic           master_led,
  input wire logic           supply_sync_clock_out,
  input wire logic           supply_sync_clock_oe,
  input wire logic           supply_sync_clock
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [31:0] rin_cnt_reg;
  logic [3:0]  pow_w;
  logic [2:0]  ena_w;
  // pin groups judged only once both sync stages have settled
  assign pow_w = {mains_on_in, key_local_in, key_remote_in, remote_power_in};
  assign ena_w = {local_enable_position, remote_enable_position, enable_in};
  // raw hold time of remote power-in; saturates so a long hold cannot wrap
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      rin_cnt_reg <= 32'h0;
    else if (!remote_power_in)
      rin_cnt_reg <= 32'h0;
    else if (rin_cnt_reg != 32'hffffffff)
      rin_cnt_reg <= rin_cnt_reg + 32'h1;
  // board reset: both pulses together, one cycle long
  sequence s_brd_pulse;
    board_reset_out && cpu_reset_out;
  endsequence
  a_power_key: assert property ($stable(pow_w) [*5] |-> power_on_out == (pow_w[3] & (pow_w[2] | pow_w[1] & pow_w[0])))
    else $error("power output disagrees with key and mains");
  a_remote_late: assert property ($rose(remote_power_out) && remote_power_in |-> rin_cnt_reg >= REMOTE_DELAY && rin_cnt_reg <= REMOTE_DELAY + 4)
    else $error("remote power out rose at the wrong time");
  a_remote_drop: assert property (!remote_power_in [*4] |-> !remote_power_out)
    else $error("remote power out stayed high");
  a_enable_leds: assert property ($stable(ena_w) [*5] |-> local_enable_led == ena_w[2] && remote_enable_led == (ena_w[1] & ena_w[0]))
    else $error("enable indicators wrong");
  a_kill_off: assert property (kill_led [*2] |-> ch_output_on == '0)
    else $error("channel on during kill");
  a_ilk_off: assert property (interlock_led [*2] |-> ch_output_on == '0 && ch_ramp_fast)
    else $error("channel on or slow during interlock");
  a_board_pulse: assert property (board_reset_out |-> s_brd_pulse ##1 !board_reset_out)
    else $error("board reset pulse malformed");
  a_sync_dir: assert property (supply_sync_clock_oe == master_led && (!supply_sync_clock_oe || supply_sync_clock == supply_sync_clock_out))
    else $error("sync connector direction wrong");
endmodule : msc_top_asserts

bind msc_top msc_top_asserts #(.REMOTE_DELAY(REMOTE_DELAY)) u_chk (.*);

// ==== tb/msc_panel_model.sv ====
// panel partner: reset button presser and foreign sync clock source
`timescale 1ns/10ps
module msc_panel_model (
  input  wire logic       clk_sys,
  input  wire logic       press_go,
  input  wire logic [7:0] press_len,
  input  wire logic       sync_run,
  output logic            reset_in,
  output logic            supply_sync_clock_in
);
  logic [7:0] left_reg = 8'h00;
  logic [5:0] div_reg = 6'h00;
  logic       ss_reg = 1'b0;
  // button held for exactly press_len cycles, then let go
  always_ff @(posedge clk_sys)
    if (press_go)
      left_reg <= press_len;
    else if (left_reg != 8'h00)
      left_reg <= left_reg - 8'h01;
  assign reset_in = (left_reg != 8'h00);
  // foreign clock, half period 50 cycles; stands still when not running
  always_ff @(posedge clk_sys)
    if (!sync_run || div_reg == 6'h31)
      div_reg <= 6'h00;
    else
      div_reg <= div_reg + 6'h01;
  always_ff @(posedge clk_sys)
    if (sync_run && div_reg == 6'h31)
      ss_reg <= ~ss_reg;
  assign supply_sync_clock_in = ss_reg;
endmodule : msc_panel_model

// ==== tb/msc_top_test.sv ====
// self-checking bench for the supply system control block
`timescale 1ns/10ps
module msc_top_test;
  import msc_pkg::*;
  localparam int unsigned CPU_H = 20;
  localparam int unsigned BRD_H = 60;
  localparam int unsigned REM_D = 30;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, press_go = 1'b0, sync_run = 1'b0;
  logic std_left_in = 1'b0, key_local_in = 1'b0, key_remote_in = 1'b0, remote_power_in = 1'b0, mains_on_in = 1'b0;
  logic local_enable_position = 1'b0, remote_enable_position = 1'b0, enable_in = 1'b0, voltage_select_in = 1'b0;
  logic current_select_in = 1'b0, kill_in = 1'b0, interlock_closed_in = 1'b0, interlock_pol_open_in = 1'b0;
  logic [7:0] reg_addr = 8'h00, press_len = 8'h00, ch_output_on;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic reset_in, supply_sync_clock_in, power_on_out, remote_power_out, ch_ramp_fast, voltage_setpoint_b_sel;
  logic current_limit_b_sel, cpu_reset_out, board_reset_out, status_std_nim, nim_led, ttl_led, local_enable_led;
  logic remote_enable_led, voltage_select_in_led, current_select_in_led, kill_led, reset_red_led, reset_orange_led, interlock_led, master_led;
  logic reset_flag_out, any_channel_on_out, supply_sync_clock_out, supply_sync_clock_oe, supply_sync_clock, ss_prev;
  logic cpu, brd, flg, saw_r, saw_o, ilk;
  int num_errors = 0, n_compared = 0, cyc = 0, n_tog = 0, n_cpu, n_brd;
  logic [2:0] ena_tab [6] = '{3'b000, 3'b100, 3'b010, 3'b011, 3'b000, 3'b100};
  logic [7:0] r_ctl [5] = '{8'h00, 8'h28, 8'h28, 8'h18, 8'h52};
  int r_len [5] = '{40, 10, 40, 80, 80};
  msc_top #(.CPU_HOLD(CPU_H), .BOARD_HOLD(BRD_H), .REMOTE_DELAY(REM_D)) u_dut (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .std_left_in, .key_local_in,
    .key_remote_in, .remote_power_in, .mains_on_in, .local_enable_position, .remote_enable_position, .enable_in,
    .voltage_select_in, .current_select_in, .kill_in, .reset_in, .interlock_closed_in, .interlock_pol_open_in,
    .supply_sync_clock_in, .power_on_out, .remote_power_out, .ch_output_on, .ch_ramp_fast, .voltage_setpoint_b_sel,
    .current_limit_b_sel, .cpu_reset_out, .board_reset_out, .status_std_nim, .nim_led, .ttl_led, .local_enable_led,
    .remote_enable_led, .voltage_select_in_led, .current_select_in_led, .kill_led, .reset_red_led, .reset_orange_led, .interlock_led,
    .master_led, .reset_flag_out, .any_channel_on_out, .supply_sync_clock_out, .supply_sync_clock_oe,
    .supply_sync_clock
  );
  msc_panel_model u_panel (.clk_sys, .press_go, .press_len, .sync_run, .reset_in, .supply_sync_clock_in);
  // 125 mhz clock
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  // cycle ceiling against hangs, plus a toggle counter for the sync line
  always @(posedge clk_sys)
  begin
    cyc++;
    ss_prev <= supply_sync_clock;
    if (ss_prev !== supply_sync_clock)
      n_tog++;
    if (cyc == 8000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one-cycle strobes; read data only in the cycle after the strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // pins pass two sync stages plus logic before they show
  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(CTRL_OFS);
    chk(d, 32'h0);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c);
    chk(d, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_sys);
      {mains_on_in, key_local_in, key_remote_in, remote_power_in} <= i[3:0];
      {std_left_in, voltage_select_in, current_select_in} <= i[2:0];
      settle();
      chk(power_on_out, i[3] & (i[2] | i[1] & i[0]));
      chk({status_std_nim, nim_led, ttl_led}, {i[2], i[2], !i[2]});
      chk({voltage_setpoint_b_sel, voltage_select_in_led, current_limit_b_sel, current_select_in_led}, {i[1], i[1], i[0], i[0]});
    end
    @(posedge clk_sys) remote_power_in <= 1'b0;
    settle();
    @(posedge clk_sys) remote_power_in <= 1'b1;
    repeat (REM_D - 4) @(posedge clk_sys);
    #1 chk(remote_power_out, 1'b0);
    repeat (12) @(posedge clk_sys);
    #1 chk(remote_power_out, 1'b1);
    $display("power and select test done");
    wr(CHAN_OFS, 32'ha5);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_sys);
      {local_enable_position, remote_enable_position, enable_in} <= ena_tab[i];
      settle();
      chk(ch_output_on, (ena_tab[i][2] | ena_tab[i][1] & ena_tab[i][0]) ? 8'ha5 : 8'h00);
      chk({local_enable_led, remote_enable_led, ch_ramp_fast}, {ena_tab[i][2], ena_tab[i][1] & ena_tab[i][0], 1'b0});
      chk(any_channel_on_out, ena_tab[i][2] | ena_tab[i][1] & ena_tab[i][0]);
    end
    $display("enable test done");
    @(posedge clk_sys) kill_in <= 1'b1;
    settle();
    chk({ch_output_on, kill_led, ch_ramp_fast}, 10'h003);
    wr(CHAN_OFS, 32'hff);
    rd(CHAN_OFS);
    chk(d, 32'h0);
    @(posedge clk_sys) kill_in <= 1'b0;
    settle();
    // channels on again, so the software kill has something to clear
    wr(CHAN_OFS, 32'hff);
    wr(CTRL_OFS, 32'h1);
    settle();
    chk({ch_output_on, kill_led}, 9'h001);
    rd(CHAN_OFS);
    chk(d, 32'h0);
    wr(CTRL_OFS, 32'h0);
    $display("kill test done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      {interlock_pol_open_in, interlock_closed_in} <= 2'(3 - i);
      ilk = (i == 1) || (i == 2);
      settle();
      chk(interlock_led, ilk);
      wr(CHAN_OFS, 32'hff);
      rd(CHAN_OFS);
      chk(d, ilk ? 32'h0 : 32'hff);
    end
    $display("interlock test done");
    for (int i = 0; i < 5; i++)
    begin
      wr(CTRL_OFS, r_ctl[i]);
      wr(CHAN_OFS, 32'ha5);
      wr(STAT_OFS, 32'h8);
      {n_cpu, n_brd, saw_r, saw_o} = '0;
      press_len <= r_len[i][7:0];
      press_go <= 1'b1;
      @(posedge clk_sys);
      press_go <= 1'b0;
      repeat (r_len[i] + 12)
      begin
        @(posedge clk_sys);
        #1;
        n_cpu += cpu_reset_out;
        n_brd += board_reset_out;
        saw_r |= reset_red_led;
        saw_o |= reset_orange_led;
      end
      brd = r_ctl[i][4] && r_len[i] > BRD_H;
      cpu = brd || (r_ctl[i][3] && r_len[i] > CPU_H && r_len[i] <= BRD_H);
      flg = (brd && r_ctl[i][6]) || (cpu && !brd && r_ctl[i][5]);
      chk(n_cpu, cpu);
      chk(n_brd, brd);
      chk({saw_r, saw_o}, {r_len[i] > CPU_H, r_len[i] > BRD_H});
      rd(STAT_OFS);
      chk(d[STAT_RST_FLAG], flg);
      chk(reset_flag_out, flg);
      rd(CHAN_OFS);
      chk(d, (brd && !r_ctl[i][1]) ? 32'h0 : 32'ha5);
    end
    $display("reset test done");
    wr(CTRL_OFS, 32'h0);
    sync_run <= 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      settle();
      n_tog = 0;
      repeat (300) @(posedge clk_sys);
      #1 chk(n_tog >= 5 && n_tog <= 7, 1'b1);
      chk({supply_sync_clock_oe, master_led}, m ? 2'b11 : 2'b00);
      sync_run <= 1'b0;
      wr(CTRL_OFS, 32'h4);
    end
    $display("sync test done");
    end_of_test();
  end
endmodule : msc_top_test
